// [ssio_defs.svh]
// Constants for the servo sequence I/O logic
`ifndef SSIO_DEFS_SVH
`define SSIO_DEFS_SVH
// Terminal function codes
`define SSIO_FN_DATA_SEL      8'h4D
`define SSIO_FN_BCAST_CANCEL  8'h4E
`define SSIO_FN_DRIVE_READY   8'h01
`define SSIO_FN_SETTLED       8'h02
`define SSIO_FN_CTRL_READY    8'h1C
// Input source code meaning "always on"
`define SSIO_SRC_ALWAYS_ON    4'hF
// Input source code meaning "not assigned"
`define SSIO_SRC_NONE         4'h0
// Number of internal positioning points
`define SSIO_POINT_COUNT      15
// Settle output format encodings
`define SSIO_FMT_LEVEL        1'b0
`define SSIO_FMT_SHOT         1'b1
// Clock rate in kHz, for time to cycle conversion
`define SSIO_CLK_KHZ          40000
`endif

// [ssio_host_model.sv]
// Host model: terminal levels and query strobes
module ssio_host_model #(
    parameter int T1_CYC    = 40, // Scaled quiet time
    parameter int GUARD_CYC = 20  // Scaled settle time
) (
    // Clock
    input  wire logic   sys_clk,
    // Terminal levels and query strobes
    output logic [15:0] term,
    output logic        qv,
    output logic        qb
);
    timeunit 1ns;
    timeprecision 1ps;
    int idle = 1000; // Cycles since frame end
    initial {term, qv, qb} = '0;
    // Quiet gap since last frame
    always @(posedge sys_clk) begin
        idle <= qv ? 0 : idle + 1;
    end
    // Change masked terminal bits on one edge
    task automatic set_bits(input logic [15:0] mask, input logic [15:0] val);
        @(posedge sys_clk);
        term <= (term & ~mask) | (val & mask);
    endtask
    // Move cancel in the quiet gap, then settle
    task automatic set_cancel(input int idx, input logic val);
        while (idle < T1_CYC) @(posedge sys_clk);
        set_bits(16'h0001 << idx, {16{val}});
        repeat (GUARD_CYC) @(posedge sys_clk);
    endtask
    // Frame end strobe; released qualifier shows junk
    task automatic query(input logic bcast);
        @(posedge sys_clk);
        qv <= 1'b1;
        qb <= bcast;
        @(posedge sys_clk);
        qv <= 1'b0;
        qb <= ~bcast;
    endtask
endmodule

// [ssio_if.sv]
// Interface carrying synchronised inputs between modules
interface ssio_sync_if;
    logic [15:0] raw;     // Raw terminal levels
    logic [15:0] synced;  // Synchronised terminal levels
    modport src  (output raw,    input  synced);
    modport sync (input  raw,    output synced);
endinterface

// [ssio_pkg.sv]
// Types for the servo sequence I/O logic
package ssio_pkg;
    // Control mode of the amplifier
    typedef enum logic [1:0] {
        SSIO_MODE_POSITION,
        SSIO_MODE_SPEED,
        SSIO_MODE_TORQUE
    } ssio_mode_type;
    // Settle output states
    typedef enum logic [1:0] {
        SSIO_ST_IDLE,
        SSIO_ST_PULSE,
        SSIO_ST_WAIT
    } ssio_settle_type;
endpackage

// [ssio_settle.sv]
// Position settled output generator, level or single-shot form
`include "ssio_defs.svh"
module ssio_settle
    import ssio_pkg::*;
#(
    parameter int TW = 24
) (
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst,
    // Conditions
    input  wire logic          cond_ok,
    input  wire logic          dev_ok,
    input  wire logic          fmt,
    input  wire logic [TW-1:0] shot_cycles,
    // Result
    output logic               settled
);
    ssio_settle_type st_reg, st_next;  // Output state
    logic [TW-1:0]   cnt_reg, cnt_next; // Pulse timer
    logic            out_reg, out_next; // Output level
    logic            fmt_seen_reg;      // Format caught after reset
    logic            fmt_seen_next;
    // Next state logic
    always_comb begin
        st_next       = st_reg;
        cnt_next      = cnt_reg;
        out_next      = out_reg;
        fmt_seen_next = 1'b1;
        if (!fmt_seen_reg) begin
            // Power-on level: on in level mode, off in shot
            out_next = (fmt == `SSIO_FMT_LEVEL);
        end else if (fmt == `SSIO_FMT_LEVEL) begin
            out_next = cond_ok;
            st_next  = SSIO_ST_IDLE;
        end else begin
            case (st_reg)
                SSIO_ST_IDLE: begin
                    out_next = 1'b0;
                    if (cond_ok) begin
                        // Start the shot pulse
                        st_next  = SSIO_ST_PULSE;
                        out_next = 1'b1;
                        cnt_next = (shot_cycles > 1) ?
                                   shot_cycles - 1'b1 : '0;
                    end
                end
                SSIO_ST_PULSE: begin
                    if (cnt_reg != '0) begin
                        cnt_next = cnt_reg - 1'b1;
                    end else begin
                        out_next = 1'b0;
                        st_next  = SSIO_ST_WAIT;
                    end
                end
                SSIO_ST_WAIT: begin
                    // Rearm only after conditions drop
                    out_next = 1'b0;
                    if (!cond_ok) begin
                        st_next = SSIO_ST_IDLE;
                    end
                end
                default: begin
                    st_next  = SSIO_ST_IDLE;
                    out_next = 1'b0;
                end
            endcase
        end
        // Lost deviation forces the output off at once
        if (fmt_seen_reg && out_reg && !dev_ok) begin
            out_next = 1'b0;
            if (st_reg == SSIO_ST_PULSE) begin
                st_next = SSIO_ST_WAIT;
            end
        end
    end
    // Register the state
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_reg       <= SSIO_ST_IDLE;
            cnt_reg      <= '0;
            out_reg      <= 1'b0;
            fmt_seen_reg <= 1'b0;
        end else begin
            st_reg       <= st_next;
            cnt_reg      <= cnt_next;
            out_reg      <= out_next;
            fmt_seen_reg <= fmt_seen_next;
        end
    end
    assign settled = out_reg;
endmodule

// [ssio_sync.sv]
// Two-stage synchroniser for the sequence input terminals
module ssio_sync #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Terminal levels
    ssio_sync_if.sync port
);
    logic [WIDTH-1:0] meta_reg;   // First stage, read only by second
    logic [WIDTH-1:0] sync_reg;   // Second stage
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_next;
    // Next values of the two stages
    always_comb begin
        meta_next = port.raw[WIDTH-1:0];
        sync_next = meta_reg;
    end
    // Register the stages
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end
    assign port.synced = sync_reg;
endmodule

// [ssio_top.sv]
// Sequence input and output logic of the servo amplifier
`include "ssio_defs.svh"
// Functional notes
// - Select high picks points, low immediate
// - Selection captured on start rising edge
// - Simultaneous change uses the new selection
// - Up to fifteen points, one immediate set
// - Functions routed to terminals by code
// - Cancel on drops broadcasts, keeps unicast
// - Always-on source rejects all broadcasts
// - Drive ready needs all six conditions
// - Control ready from stop, free run, alarm, health, phases
// - Position mode settle follows sequence state
// - Speed and torque hold settle on
// - Format picks level or shot; power-on
// - Level mode: speed and deviation windows
// - Shot mode pulses for configured time
// - Position mode, servo on, stop released: lost deviation forces settle off
// - Unassigned input reads permanently off
module ssio_top
    import ssio_pkg::*;
#(
    parameter int NTERM = 16,
    parameter int TW    = 24,
    parameter int PTS   = `SSIO_POINT_COUNT
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst,
    // Sequence input terminals
    input  wire logic [NTERM-1:0] sequence_input_terminal,
    // Input function routing: source index per function
    input  wire logic [3:0]       src_data_sel,
    input  wire logic [3:0]       src_start,
    input  wire logic [3:0]       src_bcast_cancel,
    input  wire logic [3:0]       src_servo_on,
    input  wire logic [3:0]       src_forced_stop,
    input  wire logic [3:0]       src_free_run,
    // Output routing: function code per output terminal
    input  wire logic [7:0]       out_fn0,
    input  wire logic [7:0]       out_fn1,
    input  wire logic [7:0]       out_fn2,
    // Internal status
    input  wire logic             alarm_active,
    input  wire logic             cpu_healthy,
    input  wire logic             phases_present,
    input  wire ssio_mode_type    control_mode,
    input  wire logic [31:0]      motor_speed_abs,
    input  wire logic [31:0]      deviation_abs,
    input  wire logic [31:0]      zero_speed_window,
    input  wire logic [31:0]      settle_deviation_window,
    input  wire logic             settle_output_format,
    input  wire logic [TW-1:0]    single_shot_time,
    input  wire logic [1:0]       link_baud_select,
    // Broadcast query screening
    input  wire logic             query_valid,
    input  wire logic             query_broadcast,
    // Point table selection
    input  wire logic [3:0]       point_address,
    // Outputs
    output logic                  use_points,
    output logic [3:0]            point_index,
    output logic                  start_pulse,
    output logic                  query_accept,
    output logic                  query_discard,
    output logic                  reply_enable,
    output logic                  bcast_blocked,
    output logic                  drive_ready,
    output logic                  control_ready,
    output logic                  position_settled_output,
    output logic [2:0]            out_terminal,
    output logic [TW-1:0]         host_t1_cycles
);
    // T1 figures in microseconds
    localparam int T1_38400_US  = 5000;
    localparam int T1_19200_US  = 10000;
    localparam int T1_9600_US   = 10000;
    localparam int T1_115200_US = 1700;
    localparam int KHZ = `SSIO_CLK_KHZ;
    // Cycle counts, least times round up
    localparam logic [TW-1:0] T1C_0 = TW'((T1_38400_US * KHZ + 999) / 1000);
    localparam logic [TW-1:0] T1C_1 = TW'((T1_19200_US * KHZ + 999) / 1000);
    localparam logic [TW-1:0] T1C_2 = TW'((T1_9600_US * KHZ + 999) / 1000);
    localparam logic [TW-1:0] T1C_3 = TW'((T1_115200_US * KHZ + 999) / 1000);

    ssio_sync_if sif ();  // Synchroniser link
    logic [NTERM-1:0] term_s;  // Synchronised terminals

    assign sif.raw = 16'(sequence_input_terminal);
    // Synchronise external inputs
    ssio_sync #(.WIDTH(16)) u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .port    (sif.sync)
    );
    assign term_s = sif.synced[NTERM-1:0];

    // Route one input function: none reads off, 15 always on
    function automatic logic route_in(input logic [3:0] src,
                                      input logic [NTERM-1:0] t);
        if (src == `SSIO_SRC_NONE) begin
            route_in = 1'b0;
        end else if (src == `SSIO_SRC_ALWAYS_ON) begin
            route_in = 1'b1;
        end else begin
            route_in = t[src - 4'h1];
        end
    endfunction

    logic sel_in, start_in, cancel_in, son_in, stop_in, free_in;
    always_comb begin
        sel_in    = route_in(src_data_sel,     term_s);
        start_in  = route_in(src_start,        term_s);
        cancel_in = route_in(src_bcast_cancel, term_s);
        son_in    = route_in(src_servo_on,     term_s);
        stop_in   = route_in(src_forced_stop,  term_s);
        free_in   = route_in(src_free_run,     term_s);
    end

    // Registered state and combinational terms
    logic            start_d_reg, start_d_next;   // Start history
    logic            use_reg, use_next;           // Data source
    logic [3:0]      pidx_reg, pidx_next;         // Latched point
    logic            spulse_reg, spulse_next;     // Start pulse out
    logic            acc_reg, acc_next;           // Query accepted
    logic            dis_reg, dis_next;           // Query discarded
    logic            rep_reg, rep_next;           // Reply allowed
    logic            blk_reg, blk_next;           // Broadcast blocked
    logic            drdy_reg, drdy_next;         // Drive ready
    logic            crdy_reg, crdy_next;         // Control ready
    logic            set_reg, set_next;           // Settled out
    logic [2:0]      oterm_reg, oterm_next;       // Output terminals
    logic [TW-1:0]   t1_reg, t1_next;             // Host T1 cycles
    logic            ctrl_ok;                     // Control ready term
    logic            win_ok;                      // Both windows met
    logic            dev_ok;                      // Deviation window
    logic            shot_out;                    // Settle generator
    logic            seq_force;                   // Sequence forces on

    assign dev_ok = (deviation_abs <= settle_deviation_window);
    assign win_ok = dev_ok && (motor_speed_abs <= zero_speed_window);

    // Settle output generator, level or shot
    ssio_settle #(.TW(TW)) u_settle (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .cond_ok     (win_ok),
        .dev_ok      (dev_ok),
        .fmt         (settle_output_format),
        .shot_cycles (single_shot_time),
        .settled     (shot_out)
    );

    // Map a function code to its signal level
    function automatic logic route_out(input logic [7:0] fn,
                                       input logic d, input logic c,
                                       input logic s);
        case (fn)
            `SSIO_FN_DRIVE_READY: route_out = d;
            `SSIO_FN_SETTLED:     route_out = s;
            `SSIO_FN_CTRL_READY:  route_out = c;
            default:              route_out = 1'b0;
        endcase
    endfunction

    // Next values of all output state
    always_comb begin
        start_d_next = start_in;
        use_next     = use_reg;
        pidx_next    = pidx_reg;
        spulse_next  = 1'b0;
        // Latch selection on start rise; new level wins
        if (start_in && !start_d_reg) begin
            use_next    = sel_in;
            spulse_next = 1'b1;
            // Address 0 or above the table means immediate data
            pidx_next   = (sel_in && point_address != 4'h0 &&
                           32'(point_address) <= PTS) ?
                          point_address : 4'h0;
        end
        // Broadcast screening
        blk_next = cancel_in;
        acc_next = query_valid && !(query_broadcast && cancel_in);
        dis_next = query_valid && query_broadcast && cancel_in;
        // Only accepted unicast queries get a reply
        rep_next = query_valid && !query_broadcast;
        // Control and drive readiness
        ctrl_ok   = stop_in && !free_in && !alarm_active &&
                    cpu_healthy && phases_present;
        crdy_next = ctrl_ok;
        drdy_next = son_in && ctrl_ok;
        // Settled output by control mode
        seq_force = !son_in || !stop_in;
        if (control_mode != SSIO_MODE_POSITION) begin
            set_next = 1'b1;
        end else if (alarm_active) begin
            set_next = 1'b0;
        end else if (seq_force) begin
            set_next = 1'b1;
        end else begin
            set_next = shot_out;
        end
        // Output terminal routing
        oterm_next[0] = route_out(out_fn0, drdy_reg, crdy_reg, set_reg);
        oterm_next[1] = route_out(out_fn1, drdy_reg, crdy_reg, set_reg);
        oterm_next[2] = route_out(out_fn2, drdy_reg, crdy_reg, set_reg);
        // Host timing reference from baud setting
        case (link_baud_select)
            2'h0:    t1_next = T1C_0;
            2'h1:    t1_next = T1C_1;
            2'h2:    t1_next = T1C_2;
            default: t1_next = T1C_3;
        endcase
    end

    // Register all output state
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            start_d_reg <= 1'b0;
            use_reg     <= 1'b0;
            pidx_reg    <= 4'h0;
            spulse_reg  <= 1'b0;
            acc_reg     <= 1'b0;
            dis_reg     <= 1'b0;
            rep_reg     <= 1'b0;
            blk_reg     <= 1'b0;
            drdy_reg    <= 1'b0;
            crdy_reg    <= 1'b0;
            set_reg     <= 1'b0;
            oterm_reg   <= 3'h0;
            t1_reg      <= '0;
        end else begin
            start_d_reg <= start_d_next;
            use_reg     <= use_next;
            pidx_reg    <= pidx_next;
            spulse_reg  <= spulse_next;
            acc_reg     <= acc_next;
            dis_reg     <= dis_next;
            rep_reg     <= rep_next;
            blk_reg     <= blk_next;
            drdy_reg    <= drdy_next;
            crdy_reg    <= crdy_next;
            set_reg     <= set_next;
            oterm_reg   <= oterm_next;
            t1_reg      <= t1_next;
        end
    end

    // Outputs straight from flip-flops
    assign use_points              = use_reg;
    assign point_index             = pidx_reg;
    assign start_pulse             = spulse_reg;
    assign query_accept            = acc_reg;
    assign query_discard           = dis_reg;
    assign reply_enable            = rep_reg;
    assign bcast_blocked           = blk_reg;
    assign drive_ready             = drdy_reg;
    assign control_ready           = crdy_reg;
    assign position_settled_output = set_reg;
    assign out_terminal            = oterm_reg;
    assign host_t1_cycles          = t1_reg;
endmodule

// [ssio_top_asserts.sv]
// Port checks for the sequence I/O top level
`include "ssio_defs.svh"
module ssio_top_chk
    import ssio_pkg::*;
(
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // Watched inputs
    input wire logic        query_valid,
    input wire logic        query_broadcast,
    input wire logic [7:0]  out_fn0,
    input wire logic [7:0]  out_fn1,
    input wire logic [1:0]  control_mode,
    input wire logic        cpu_healthy,
    input wire logic [31:0] deviation_abs,
    input wire logic [31:0] settle_deviation_window,
    // Watched outputs
    input wire logic        use_points,
    input wire logic [3:0]  point_index,
    input wire logic        start_pulse,
    input wire logic        query_accept,
    input wire logic        query_discard,
    input wire logic        reply_enable,
    input wire logic        bcast_blocked,
    input wire logic        drive_ready,
    input wire logic        control_ready,
    input wire logic        position_settled_output,
    input wire logic [2:0]  out_terminal
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Start and source selection
    a_start_one_cycle: assert property (start_pulse |=> !start_pulse)
        else $error("start pulse stretched");
    a_select_on_start: assert property (
        $changed(use_points) |-> start_pulse)
        else $error("source moved without start");
    a_immediate_point: assert property (
        start_pulse && !use_points |-> point_index == 4'h0)
        else $error("point set for immediate data");
    // Query screening
    a_unicast_served: assert property (
        query_valid && !query_broadcast
        |=> query_accept && reply_enable && !query_discard)
        else $error("unicast not served");
    a_bcast_dropped: assert property (
        query_valid && query_broadcast && bcast_blocked && $past(bcast_blocked)
        |=> query_discard && !query_accept && !reply_enable)
        else $error("broadcast not dropped");
    a_bcast_open: assert property (
        query_valid && query_broadcast && !bcast_blocked
        && !$past(bcast_blocked)
        |=> query_accept && !query_discard && !reply_enable)
        else $error("broadcast not taken");
    a_query_idle: assert property (
        !query_valid |=> !query_accept && !query_discard)
        else $error("result without query");
    // Readiness and settled
    a_ctrl_health: assert property (!cpu_healthy |=> !control_ready)
        else $error("control ready on fault");
    a_drive_health: assert property (
        !cpu_healthy [*2] |=> !drive_ready)
        else $error("drive ready on fault");
    a_mode_settled: assert property (
        control_mode != SSIO_MODE_POSITION [*3] |=> position_settled_output)
        else $error("settled off in speed mode");
    a_dev_lost_off: assert property (
        (control_mode == SSIO_MODE_POSITION && drive_ready
         && deviation_abs > settle_deviation_window) [*3]
        |=> !position_settled_output)
        else $error("settled on, deviation lost");
    // Output routing
    a_route_drive: assert property (
        out_fn0 == `SSIO_FN_DRIVE_READY
        |=> out_terminal[0] == $past(drive_ready))
        else $error("drive ready misrouted");
    a_route_ctrl: assert property (
        out_fn1 == `SSIO_FN_CTRL_READY
        |=> out_terminal[1] == $past(control_ready))
        else $error("control ready misrouted");
    // Main scenarios reached
    c_start_points: cover property (start_pulse && use_points);
    c_bcast_drop: cover property (query_discard);
    c_pos_settled: cover property (
        control_mode == SSIO_MODE_POSITION && $rose(position_settled_output));
endmodule
bind ssio_top ssio_top_chk chk (.*);

// [ssio_top_tb.sv]
// Self-checking bench for the sequence I/O top level
`include "ssio_defs.svh"
module ssio_top_tb
    import ssio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int K = `SSIO_CLK_KHZ;
    // Expected tables
    localparam int T1_EXP [4] = '{5 * K, 10 * K, 10 * K, 17 * K / 10};
    localparam logic [19:0] CSRC = 20'hF_3330;
    localparam logic [4:0]  CLV  = 5'h06;
    localparam logic [4:0]  QB   = 5'h1B;
    localparam logic [14:0] QEXP = 15'h2954;
    logic          sys_clk = 1'b0;
    logic          rst = 1'b1;
    wire  [15:0]   term;
    wire           qv, qb;
    logic [3:0]    s_sel = 4'h1, s_start = 4'h2, s_cancel = 4'h0;
    logic [3:0]    s_son = 4'h4, s_stop = 4'h5, s_free = 4'h6;
    logic          alarm = 1'b0, cpu_ok = 1'b1, phases = 1'b1, fmt = 1'b0;
    ssio_mode_type mode = SSIO_MODE_SPEED;
    logic [31:0]   spd = 32'h0000_0000, dev = 32'h0000_0000;
    logic [23:0]   shot = 24'h00_0005;
    logic [1:0]    baud = 2'h0;
    logic [3:0]    pt = 4'h1;
    logic          use_p, start_p, acc, disc, rep, drv, ctl, setl;
    logic [3:0]    pidx;
    logic [2:0]    oterm, e3;
    logic [23:0]   t1;
    int            mismatches = 0, comparisons = 0, cycles = 0, hi;
    logic [4:0]    start_q [$];
    logic [2:0]    query_q [$];
    logic [4:0]    e5;
    logic [31:0]   r;
    logic [5:0]    b;
    logic          sel;
    ssio_host_model h (.sys_clk, .term, .qv, .qb);
    ssio_top uut (
        .sys_clk, .rst, .sequence_input_terminal(term),
        .src_data_sel(s_sel), .src_start(s_start),
        .src_bcast_cancel(s_cancel), .src_servo_on(s_son),
        .src_forced_stop(s_stop), .src_free_run(s_free),
        .out_fn0(`SSIO_FN_DRIVE_READY), .out_fn1(`SSIO_FN_CTRL_READY),
        .out_fn2(`SSIO_FN_SETTLED), .alarm_active(alarm),
        .cpu_healthy(cpu_ok), .phases_present(phases), .control_mode(mode),
        .motor_speed_abs(spd), .deviation_abs(dev),
        .zero_speed_window(32'h0000_0064),
        .settle_deviation_window(32'h0000_0032),
        .settle_output_format(fmt), .single_shot_time(shot),
        .link_baud_select(baud), .query_valid(qv), .query_broadcast(qb),
        .point_address(pt), .use_points(use_p), .point_index(pidx),
        .start_pulse(start_p), .query_accept(acc), .query_discard(disc),
        .reply_enable(rep), .bcast_blocked(), .drive_ready(drv),
        .control_ready(ctl), .position_settled_output(setl),
        .out_terminal(oterm), .host_t1_cycles(t1)
    );
    initial forever #12.5 sys_clk = ~sys_clk;
    // Compare and count
    task automatic check(input string n, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Wait edges, then sample mid-cycle
    task automatic look(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            close_out();
        end
    end
    // Match results with oldest notes
    always @(negedge sys_clk) begin
        if (start_p === 1'b1) begin
            e5 = start_q.size() ? start_q.pop_front() : 'x;
            check("start", {use_p, pidx}, e5);
        end
        if ((acc | disc | rep) === 1'b1) begin
            e3 = query_q.size() ? query_q.pop_front() : 'x;
            check("query", {acc, disc, rep}, e3);
        end
    end
    // Main sequence
    initial begin
        void'($urandom(32'h10ff_432e));
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            baud <= i[1:0];
            look(2);
            check("host_t1", t1, T1_EXP[i]);
        end
        // Interlock mixes
        for (int i = 0; i < 24; i++) begin
            r = $urandom;
            b = r[5:0] & r[13:8] & {6{i != 0}};
            h.set_bits(16'h0038, {10'h000, b[2], ~b[1], ~b[0], 3'h0});
            alarm <= b[3];
            cpu_ok <= ~b[4];
            phases <= ~b[5];
            mode <= i[0] ? SSIO_MODE_TORQUE : SSIO_MODE_SPEED;
            look(5);
            check("ctl", ctl, ~|b[5:1]);
            check("drv", drv, ~|b);
            check("out0", oterm[0], ~|b);
            check("out1", oterm[1], ~|b[5:1]);
            check("out2", oterm[2], 1);
        end
        // Stop source unassigned, then always on
        h.set_bits(16'h0038, 16'h0008);
        alarm <= 1'b0;
        cpu_ok <= 1'b1;
        phases <= 1'b1;
        s_stop <= 4'h0;
        look(5);
        check("ctl_none", ctl, 0);
        @(posedge sys_clk);
        s_stop <= 4'hF;
        look(5);
        check("ctl_always", ctl, 1);
        h.set_bits(16'h0010, 16'h0010);
        s_stop <= 4'h5;
        // Selection and start rise together
        for (int i = 0; i < 8; i++) begin
            r = $urandom;
            sel = r[4];
            h.set_bits(16'h0001, {15'h0000, ~sel});
            pt <= (r[3:0] == 4'h0) ? 4'h1 : r[3:0];
            look(4);
            start_q.push_back({sel, sel ? pt : 4'h0});
            h.set_bits(16'h0003, {14'h0000, 1'b1, sel});
            look(5);
            h.set_bits(16'h0003, {14'h0000, 1'b0, ~sel});
            look(3);
        end
        // Broadcast screening table
        for (int i = 0; i < 5; i++) begin
            @(posedge sys_clk);
            s_cancel <= CSRC[i*4 +: 4];
            h.set_cancel(2, CLV[i]);
            query_q.push_back(QEXP[i*3 +: 3]);
            h.query(QB[i]);
        end
        look(3);
        // Position mode, level form
        @(posedge sys_clk);
        mode <= SSIO_MODE_POSITION;
        spd <= $urandom_range(100, 0);
        dev <= $urandom_range(50, 0);
        look(6);
        check("settle_in", setl, 1);
        @(posedge sys_clk);
        dev <= 32'h0000_0033 + $urandom_range(1000, 0);
        look(2);
        check("settle_lost", setl, 0);
        @(posedge sys_clk);
        dev <= 32'h0000_0000;
        alarm <= 1'b1;
        look(4);
        check("settle_alarm", setl, 0);
        h.set_bits(16'h0008, 16'h0000);
        alarm <= 1'b0;
        dev <= 32'h0000_0100;
        look(5);
        check("settle_free", setl, 1);
        // Single-shot form
        h.set_bits(16'h0008, 16'h0008);
        fmt <= 1'b1;
        look(8);
        check("shot_idle", setl, 0);
        @(posedge sys_clk);
        dev <= 32'h0000_0010;
        hi = 0;
        repeat (20) begin
            @(negedge sys_clk);
            hi += setl;
        end
        check("shot_len", hi, shot);
        check("start_left", start_q.size(), 0);
        check("query_left", query_q.size(), 0);
        close_out();
    end
endmodule
